// *** pkg/dau_regs.svh ***
// Notes on behaviour
// - Once a whole word has arrived, a low load pin copies the input register into the DAC register.
// - No pin-driven copy happens while a serial word is still being shifted in.
// - A low load pin before the third data byte completes powers up only, leaving the DAC register alone.
// - A load pin still low when the 24-bit word ends runs the command and also updates the DAC register.
// - A low load pin always powers the converter up, whatever the serial bus is doing.
// - A low load pin at the ninth falling clock of the third data byte cancels a power-down in that word.
// - Command codes: 0000 write, 0001 update, 0011 write and update, 0100 power down, 1111 no-op.
// - A write loads the 16-bit data into the input register; an update copies it to the DAC register.
// - A command runs only after all three data bytes behind a matching address have arrived.
// - Every update also brings the converter out of power-down.
`ifndef DAU_REGS_SVH
`define DAU_REGS_SVH

// ----------------------------------------
// Addressing and framing
// ----------------------------------------
`define DAU_GLOBAL_ADDR 7'h73
`define DAU_WORD_BYTES  2'h3
`define DAU_ACK_BIT     4'h8
`define DAU_LAST_BIT    4'h9

// ----------------------------------------
// Word fields
// ----------------------------------------
`define DAU_CMD_MSB     23
`define DAU_CMD_LSB     20
`define DAU_DATA_MSB    15
`define DAU_DATA_LSB    0

// ----------------------------------------
// Command codes
// ----------------------------------------
`define DAU_CMD_WRITE   4'h0
`define DAU_CMD_UPDATE  4'h1
`define DAU_CMD_WR_UPD  4'h3
`define DAU_CMD_PDOWN   4'h4
`define DAU_CMD_NOP     4'hF

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DAU_CODE_RST    16'h0000
`define DAU_PD_RST      1'h0
`define DAU_CMD_RST     4'hF

`endif

// *** pkg/dau_pkg.sv ***
`default_nettype none
package dau_pkg;
  typedef enum logic [1:0] {
    DAU_IDLE,
    DAU_ADDR,
    DAU_DATA,
    DAU_SKIP
  } dau_state_t;

  typedef logic [3:0]  dau_cmd_t;
  typedef logic [15:0] dau_code_t;
endpackage
`default_nettype wire

// *** src/dau_sync.sv ***
`default_nettype none
module dau_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] rst_val_i,
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  // Reset value is a tie-off constant at every instance
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta_ff <= rst_val_i;
      sync_o  <= rst_val_i;
    end else if (ce_i) begin
      meta_ff <= async_i;
      sync_o  <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// *** src/dau_top.sv ***
`include "dau_regs.svh"
`default_nettype none
module dau_top
  import dau_pkg::*;
(
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  input  wire logic             ce_i,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output var  logic             sda_o,
  output var  logic             sda_oe_n_o,
  input  wire logic             async_load_n_i,
  input  wire logic [6:0]       slave_addr_i,
  output var  dau_pkg::dau_code_t input_code_o,
  output var  dau_pkg::dau_code_t dac_code_o,
  output var  logic             power_down_o,
  output var  logic             word_done_o,
  output var  dau_pkg::dau_cmd_t  last_cmd_o
);
  import dau_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0]  pins_sync;
  logic [6:0]  addr_sync;
  logic        scl_s;
  logic        sda_s;
  logic        load_n_s;
  logic        scl_q_ff;
  logic        sda_q_ff;

  dau_sync #(
    .W (3)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .rst_val_i (3'h7),
    .async_i   ({scl_i, sda_i, async_load_n_i}),
    .sync_o    (pins_sync)
  );

  // Address straps are static, but still cross the domain like any pin
  dau_sync #(
    .W (7)
  ) u_addr_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .rst_val_i (7'h00),
    .async_i   (slave_addr_i),
    .sync_o    (addr_sync)
  );

  assign scl_s    = pins_sync[2];
  assign sda_s    = pins_sync[1];
  assign load_n_s = pins_sync[0];

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      scl_q_ff <= 1'h1;
      sda_q_ff <= 1'h1;
    end else if (ce_i) begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end

  // ----------------------------------------
  // Bus events
  // ----------------------------------------
  wire scl_rise = scl_s & ~scl_q_ff;
  wire scl_fall = ~scl_s & scl_q_ff;
  wire bus_start = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  wire bus_stop  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  wire load_low  = ~load_n_s;

  // ----------------------------------------
  // Receiver state
  // ----------------------------------------
  dau_state_t  state_ff;
  dau_state_t  nxt_state;
  logic [3:0]  bit_cnt_ff;
  logic [3:0]  nxt_bit_cnt;
  logic [1:0]  byte_cnt_ff;
  logic [1:0]  nxt_byte_cnt;
  logic [23:0] word_ff;
  logic [23:0] nxt_word;
  logic        ack_ff;
  logic        nxt_ack;

  wire [7:0] last_byte  = word_ff[7:0];
  wire       addr_match = (last_byte[7:1] == addr_sync) || (last_byte[7:1] == `DAU_GLOBAL_ADDR);
  wire       addr_write = ~last_byte[0];
  wire       ack_time   = scl_fall && (bit_cnt_ff == `DAU_ACK_BIT);
  wire       byte_end   = scl_fall && (bit_cnt_ff == `DAU_LAST_BIT);
  wire       in_word    = (state_ff == DAU_DATA) && (byte_cnt_ff != `DAU_WORD_BYTES);

  // Command runs at the ninth falling clock of the third byte
  wire       word_end   = byte_end && in_word && (byte_cnt_ff == `DAU_WORD_BYTES - 2'h1);

  // Pin copy is held off while a word is in flight
  wire       word_busy  = in_word;

  always_comb begin
    nxt_state    = state_ff;
    nxt_bit_cnt  = bit_cnt_ff;
    nxt_byte_cnt = byte_cnt_ff;
    nxt_word     = word_ff;
    nxt_ack      = ack_ff;
    if (bus_start) begin
      nxt_state    = DAU_ADDR;
      nxt_bit_cnt  = 4'h0;
      nxt_byte_cnt = 2'h0;
      nxt_ack      = 1'h0;
    end else if (bus_stop) begin
      nxt_state = DAU_IDLE;
      nxt_ack   = 1'h0;
    end else if (state_ff != DAU_IDLE) begin
      if (scl_rise) begin
        if (bit_cnt_ff < `DAU_ACK_BIT) begin
          nxt_word = {word_ff[22:0], sda_s};
        end
        nxt_bit_cnt = bit_cnt_ff + 4'h1;
      end else if (ack_time) begin
        case (state_ff)
          DAU_ADDR: begin
            nxt_ack = addr_match & addr_write;
          end
          DAU_DATA: begin
            // Bytes beyond the third are refused
            nxt_ack = (byte_cnt_ff != `DAU_WORD_BYTES);
          end
          default: begin
            nxt_ack = 1'h0;
          end
        endcase
      end else if (byte_end) begin
        nxt_ack     = 1'h0;
        nxt_bit_cnt = 4'h0;
        case (state_ff)
          DAU_ADDR: begin
            nxt_state = ack_ff ? DAU_DATA : DAU_SKIP;
          end
          DAU_DATA: begin
            if (in_word) begin
              nxt_byte_cnt = byte_cnt_ff + 2'h1;
            end
          end
          default: begin
            nxt_state = DAU_SKIP;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_ff    <= DAU_IDLE;
      bit_cnt_ff  <= 4'h0;
      byte_cnt_ff <= 2'h0;
      word_ff     <= 24'h000000;
      ack_ff      <= 1'h0;
    end else if (ce_i) begin
      state_ff    <= nxt_state;
      bit_cnt_ff  <= nxt_bit_cnt;
      byte_cnt_ff <= nxt_byte_cnt;
      word_ff     <= nxt_word;
      ack_ff      <= nxt_ack;
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  wire [3:0]  cmd       = word_ff[`DAU_CMD_MSB:`DAU_CMD_LSB];
  wire [15:0] word_data = word_ff[`DAU_DATA_MSB:`DAU_DATA_LSB];

  wire cmd_write  = (cmd == `DAU_CMD_WRITE) || (cmd == `DAU_CMD_WR_UPD);
  wire cmd_update = (cmd == `DAU_CMD_UPDATE) || (cmd == `DAU_CMD_WR_UPD);
  wire cmd_pdown  = (cmd == `DAU_CMD_PDOWN);

  // ----------------------------------------
  // Data and power registers
  // ----------------------------------------
  dau_code_t input_ff;
  dau_code_t nxt_input;
  dau_code_t dac_ff;
  dau_code_t nxt_dac;
  logic      pd_ff;
  logic      nxt_pd;
  dau_cmd_t  cmd_ff;
  dau_cmd_t  nxt_cmd;

  always_comb begin
    nxt_input = input_ff;
    nxt_dac   = dac_ff;
    nxt_pd    = pd_ff;
    nxt_cmd   = cmd_ff;
    if (word_end) begin
      nxt_cmd = cmd;
      if (cmd_write) begin
        nxt_input = word_data;
      end
      if (cmd_update || load_low) begin
        nxt_dac = cmd_write ? word_data : input_ff;
      end
      if (cmd_update) begin
        nxt_pd = 1'h0;
      end else if (cmd_pdown && !load_low) begin
        nxt_pd = 1'h1;
      end
    end else if (load_low && !word_busy) begin
      nxt_dac = input_ff;
    end
    if (load_low) begin
      nxt_pd = 1'h0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      input_ff <= `DAU_CODE_RST;
      dac_ff   <= `DAU_CODE_RST;
      pd_ff    <= `DAU_PD_RST;
      cmd_ff   <= `DAU_CMD_RST;
    end else if (ce_i) begin
      input_ff <= nxt_input;
      dac_ff   <= nxt_dac;
      pd_ff    <= nxt_pd;
      cmd_ff   <= nxt_cmd;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Open drain: the line is only ever pulled low, so data stays zero
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sda_o       <= 1'h0;
      sda_oe_n_o  <= 1'h1;
      word_done_o <= 1'h0;
    end else if (ce_i) begin
      sda_o       <= 1'h0;
      sda_oe_n_o  <= ~nxt_ack;
      word_done_o <= word_end;
    end
  end

  assign input_code_o = input_ff;
  assign dac_code_o   = dac_ff;
  assign power_down_o = pd_ff;
  assign last_cmd_o   = cmd_ff;
endmodule
`default_nettype wire

// *** sim/dau_chk.sv ***
`include "dau_regs.svh"
`default_nettype none
module dau_chk (
  input wire logic               clk_sys_i,
  input wire logic               reset_i,
  input wire logic               ce_i,
  input wire logic               scl_i,
  input wire logic               async_load_n_i,
  input wire logic               sda_oe_n_o,
  input wire dau_pkg::dau_code_t input_code_o,
  input wire dau_pkg::dau_code_t dac_code_o,
  input wire logic               power_down_o,
  input wire logic               word_done_o,
  input wire dau_pkg::dau_cmd_t  last_cmd_o
);
  timeunit 1ns;
  timeprecision 10ps;
  import dau_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // ----
  // Steps
  // ----
  sequence pin_low_s;
    (!async_load_n_i && ce_i) [*5];
  endsequence
  sequence ack_hold_s;
    !sda_oe_n_o [*5];
  endsequence
  property pd_cause_p;
    $rose(power_down_o) |-> word_done_o && last_cmd_o == `DAU_CMD_PDOWN;
  endproperty
  property in_write_p;
    $changed(input_code_o) |-> word_done_o && last_cmd_o inside {`DAU_CMD_WRITE, `DAU_CMD_WR_UPD};
  endproperty
  a_pin_power_up: assert property (pin_low_s |-> !power_down_o)
    else $error("powered down with load pin low");
  a_done_pulse: assert property (word_done_o |=> !word_done_o)
    else $error("word done too wide");
  a_pd_cause: assert property (pd_cause_p)
    else $error("power down without its command");
  a_dac_source: assert property ($changed(dac_code_o) |-> dac_code_o == input_code_o)
    else $error("dac code not from input register");
  a_input_write: assert property (in_write_p)
    else $error("input register changed without write");
  a_ack_hold: assert property ($fell(sda_oe_n_o) |=> ack_hold_s)
    else $error("ack too short");
  a_ack_release: assert property ($fell(sda_oe_n_o) |-> ##[8:20] $rose(sda_oe_n_o))
    else $error("ack not released");
  a_ack_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("data line moved with clock high");
endmodule
bind dau_top dau_chk u_chk (.clk_sys_i, .reset_i, .ce_i, .scl_i, .async_load_n_i, .sda_oe_n_o,
  .input_code_o, .dac_code_o, .power_down_o, .word_done_o, .last_cmd_o);
`default_nettype wire

// *** sim/dau_master.sv ***
`default_nettype none
module dau_master (
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o,
  output var  logic async_load_n_o
);
  timeunit 1ns;
  timeprecision 10ps;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    async_load_n_o = 1'b1;
  end
  // ----
  // Bus cycles
  // ----
  // Data moves mid-low so it never reads as a start or stop
  task automatic put_bit(input logic b, output logic s);
    #31.25 sda_o = b;
    #31.25 scl_o = 1'b1;
    #31.25 s = sda_i;
    #31.25 scl_o = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, nak);
  endtask
  task automatic send_word(input logic [6:0] a, input logic [3:0] c, input logic [15:0] d,
                           input logic [1:0] m, output logic [3:0] nak);
    // Half a nanosecond off the clock grid keeps every pin change clear of a sampling edge
    #63 sda_o = 1'b0;
    #62.5 scl_o = 1'b0;
    send_byte({a, 1'b0}, nak[3]);
    send_byte({c, 4'h5}, nak[2]);
    async_load_n_o = (m == 2'h0);
    send_byte(d[15:8], nak[1]);
    async_load_n_o = (m != 2'h2);
    send_byte(d[7:0], nak[0]);
    #31.25 sda_o = 1'b0;
    #31.25 scl_o = 1'b1;
    #62.5 sda_o = 1'b1;
    async_load_n_o = (m != 2'h3);
    #100 async_load_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** sim/dau_top_bench.sv ***
`include "dau_regs.svh"
`default_nettype none
module dau_top_bench;
  timeunit 1ns;
  timeprecision 10ps;
  import dau_pkg::*;
  typedef struct packed {
    logic [6:0]  a;
    logic [3:0]  c;
    logic [15:0] d;
    logic [1:0]  m;
    logic        n;
    logic [15:0] i;
    logic [15:0] o;
    logic        p;
    logic [3:0]  l;
  } dau_row_t;
  // ----
  // Rows: each starts from the state the one above leaves
  // ----
  localparam dau_row_t ROWS [12] = '{
    '{7'h10,4'h0,16'h1234,2'h0,1'h0,16'h1234,16'h0000,1'h0,4'h0},
    '{7'h10,4'h4,16'h0000,2'h0,1'h0,16'h1234,16'h0000,1'h1,4'h4},
    '{7'h10,4'hF,16'h5555,2'h0,1'h0,16'h1234,16'h0000,1'h1,4'hF},
    '{7'h10,4'h0,16'h0F0F,2'h1,1'h0,16'h0F0F,16'h0000,1'h0,4'h0},
    '{7'h10,4'h4,16'h0000,2'h0,1'h0,16'h0F0F,16'h0000,1'h1,4'h4},
    '{7'h10,4'h1,16'h0000,2'h0,1'h0,16'h0F0F,16'h0F0F,1'h0,4'h1},
    '{`DAU_GLOBAL_ADDR,4'h3,16'hABCD,2'h0,1'h0,16'hABCD,16'hABCD,1'h0,4'h3},
    '{7'h10,4'h4,16'h0000,2'h2,1'h0,16'hABCD,16'hABCD,1'h0,4'h4},
    '{7'h10,4'h0,16'h7777,2'h2,1'h0,16'h7777,16'h7777,1'h0,4'h0},
    '{7'h10,4'h4,16'h0000,2'h0,1'h0,16'h7777,16'h7777,1'h1,4'h4},
    '{7'h10,4'h0,16'h1111,2'h3,1'h0,16'h1111,16'h1111,1'h0,4'h0},
    '{7'h11,4'h3,16'h2222,2'h0,1'h1,16'h1111,16'h1111,1'h0,4'h0}
  };
  logic       clk_sys_i = 1'b0;
  logic       reset_i   = 1'b1;
  logic       scl, sda_m, async_load_n, sda_o, sda_oe_n_o, pd, done;
  logic [3:0] nak;
  dau_code_t  in_c, dac_c;
  dau_cmd_t   last;
  int         errors  = 0;
  int         n_tests = 0;
  int         n_done  = 0;
  int         done0;
  // Open drain with pull-up
  wire logic  sda_w = sda_m & (sda_oe_n_o | sda_o);
  dau_top dut (.clk_sys_i, .reset_i, .ce_i(1'b1), .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe_n_o,
    .async_load_n_i(async_load_n), .slave_addr_i(7'h10), .input_code_o(in_c), .dac_code_o(dac_c),
    .power_down_o(pd), .word_done_o(done), .last_cmd_o(last));
  dau_master u_master (.sda_i(sda_w), .scl_o(scl), .sda_o(sda_m), .async_load_n_o(async_load_n));
  always #5 clk_sys_i = ~clk_sys_i;
  // Counts done cycles, so a stretched pulse shows up as an extra word
  always @(posedge clk_sys_i) begin
    if (done === 1'b1)
      n_done++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Compares %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check_state(input dau_row_t r);
    repeat (10) @(negedge clk_sys_i);
    chk(in_c, r.i);
    chk(dac_c, r.o);
    chk(16'(pd), 16'(r.p));
    chk(16'(last), 16'(r.l));
  endtask
  initial begin
    repeat (5) @(negedge clk_sys_i);
    reset_i = 1'b0;
    repeat (10) @(negedge clk_sys_i);
    foreach (ROWS[k]) begin
      done0 = n_done;
      u_master.send_word(ROWS[k].a, ROWS[k].c, ROWS[k].d, ROWS[k].m, nak);
      chk(16'(nak), 16'({4{ROWS[k].n}}));
      check_state(ROWS[k]);
      chk(16'(n_done - done0), 16'(!ROWS[k].n));
      $display("Row %0d done", k);
    end
    reset_i = 1'b1;
    check_state('{7'h00,4'h0,16'h0000,2'h0,1'h0,16'h0000,16'h0000,1'h0,4'hF});
    reset_i = 1'b0;
    check_state('{7'h00,4'h0,16'h0000,2'h0,1'h0,16'h0000,16'h0000,1'h0,4'hF});
    u_master.send_word(7'h10, `DAU_CMD_WR_UPD, 16'h4321, 2'h0, nak);
    chk(16'(nak), 16'h0000);
    check_state('{7'h10,4'h3,16'h4321,2'h0,1'h0,16'h4321,16'h4321,1'h0,4'h3});
    $display("Reset test done");
    finish_test();
  end
  // Thirteen words take about 65 us
  initial begin
    #200us;
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
